// ---- rtl/tec_pkg.sv ----
// Shared constants and carrier types of the timer/event counter
package tec_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CCC = 8'h04;
    localparam logic [7:0] ADDR_OPC = 8'h08;
    localparam logic [7:0] ADDR_PEM = 8'h0C;
    localparam logic [7:0] ADDR_CSC = 8'h10;
    localparam logic [7:0] ADDR_CNT = 8'h14;
    localparam logic [7:0] ADDR_CRA = 8'h18;
    localparam logic [7:0] ADDR_CRB = 8'h1C;
    // Field positions
    localparam int MODE_LSB = 2;
    localparam int TCOND_BIT = 1;
    localparam int OVF_BIT = 0;
    localparam int CCC_A_CAP = 0;
    localparam int CCC_A_REV = 1;
    localparam int CCC_B_CAP = 2;
    localparam int OPC_TOE = 0;
    localparam int OPC_TOG_A = 1;
    localparam int OPC_LVR = 2;
    localparam int OPC_LVS = 3;
    localparam int OPC_TOG_B = 4;
    localparam int PEM_CS_LSB = 0;
    localparam int PEM_ESA_LSB = 4;
    localparam int PEM_ESB_LSB = 6;
    localparam int CSC_EXT_BIT = 0;
    // Mode field codes
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_CLR_EDGE = 2'h2;
    localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
    // Count clock select codes
    localparam logic [1:0] CS_EVENT = 2'h3;
    localparam logic [1:0] CS_INTWT = 2'h2;
    // Edge select codes
    localparam logic [1:0] ES_FALL = 2'h0;
    localparam logic [1:0] ES_RISE = 2'h1;
    localparam logic [1:0] ES_BOTH = 2'h3;
    // Reset values and limits
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [3:0] DIV_RST = 4'h0;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tec_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tec_apb_rsp_t;
endpackage

// ---- rtl/tec_edge_det.sv ----
// Input synchroniser, two-sample noise filter and edge detector
`timescale 1ns/1ps
module tec_edge_det (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic en,
    input wire logic [1:0] es,
    // Pin and events
    input wire logic pin,
    output logic edge_valid,
    output logic edge_rev
);
    import tec_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic samp;
        logic filt;
        logic rise;
        logic fall;
    } tec_edge_st_t;

    tec_edge_st_t s_ff;
    tec_edge_st_t nxt_s_ff;

    always_comb
    begin
        nxt_s_ff = s_ff;
        nxt_s_ff.sync1 = pin;
        nxt_s_ff.sync2 = s_ff.sync1;
        nxt_s_ff.samp = s_ff.sync2;
        nxt_s_ff.rise = 1'b0;
        nxt_s_ff.fall = 1'b0;
        // Filtered level starts low, so a high pin reads as a rising edge
        if (!en)
        begin
            nxt_s_ff.filt = 1'b0;
        end
        else if (s_ff.sync2 == s_ff.samp && s_ff.samp != s_ff.filt)
        begin
            nxt_s_ff.filt = s_ff.samp;
            nxt_s_ff.rise = s_ff.samp;
            nxt_s_ff.fall = !s_ff.samp;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s_ff;
        end
    end

    always_comb
    begin
        case (es)
            ES_RISE:
            begin
                edge_valid = s_ff.rise;
                edge_rev = s_ff.fall;
            end
            ES_BOTH:
            begin
                edge_valid = s_ff.rise | s_ff.fall;
                edge_rev = s_ff.rise | s_ff.fall;
            end
            default:
            begin
                edge_valid = s_ff.fall;
                edge_rev = s_ff.rise;
            end
        endcase
    end
endmodule // tec_edge_det

// ---- rtl/tec_clk_sel.sv ----
// Count clock divider and selector, gives one-cycle count enables
`timescale 1ns/1ps
module tec_clk_sel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Selection
    input wire logic run,
    input wire logic ext,
    input wire logic [1:0] sel,
    input wire logic ext_edge,
    // Count enable
    output logic tick
);
    import tec_pkg::*;

    typedef struct packed {
        logic [3:0] div;
    } tec_div_st_t;

    tec_div_st_t s_ff;
    tec_div_st_t nxt_s_ff;

    always_comb
    begin
        nxt_s_ff = s_ff;
        nxt_s_ff.div = run ? s_ff.div + 4'h1 : DIV_RST;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s_ff;
        end
    end

    // Watch timer source is not wired here, that code never counts while ext is clear
    always_comb
    begin
        case ({ext, sel})
            3'h0: tick = run;
            3'h1: tick = run & (s_ff.div[1:0] == 2'h3);
            3'h3: tick = run & ext_edge;
            3'h4: tick = run & s_ff.div[0];
            3'h5: tick = run & (s_ff.div[2:0] == 3'h7);
            3'h6: tick = run & (s_ff.div == 4'hF);
            default: tick = 1'b0;
        endcase
    end
endmodule // tec_clk_sel

// ---- rtl/tec_timer.sv ----
// Timer/event counter core with APB register file
`timescale 1ns/1ps

module tec_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire tec_pkg::tec_apb_req_t apb_req,
    output tec_pkg::tec_apb_rsp_t apb_rsp,
    // External pins
    input wire logic event_input_a,
    input wire logic event_input_b,
    output logic timer_output_pin,
    // Interrupt requests
    output logic match_a_interrupt,
    output logic match_b_interrupt
);
    import tec_pkg::*;

    typedef struct packed {
        logic [1:0] mode;
        logic output_toggle_condition;
        logic overflow_flag;
        logic [7:0] capture_compare_control;
        logic [7:0] output_pin_control;
        logic [7:0] prescaler_edge_mode;
        logic [7:0] clock_selector_control;
        logic [15:0] up_counter_value;
        logic [15:0] capture_compare_a;
        logic [15:0] capture_compare_b;
        logic started;
        logic tout;
        logic irq_a;
        logic irq_b;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tec_state_t;

    tec_state_t s_ff;
    tec_state_t nxt_s_ff;

    ////////////////////////////////////////////////////////////////////////
    // Decoded controls

    logic run;
    logic tick;
    logic edge_a;
    logic edge_a_rev;
    logic edge_b;
    logic event_sel;
    logic a_cap;
    logic b_cap;
    logic match_a_cmp;
    logic match_b_cmp;
    logic clr_match;
    logic clr_edge;
    logic hold_clr;
    logic cap_a_trig;
    logic cap_b_trig;
    logic ovf_set;
    logic toggle;
    logic any_clr;
    logic setup;
    logic wr;
    logic [7:0] wb;

    assign run = s_ff.mode != MODE_STOP;
    assign event_sel = (s_ff.prescaler_edge_mode[PEM_CS_LSB +: 2] == CS_EVENT)
        && !s_ff.clock_selector_control[CSC_EXT_BIT];
    assign a_cap = s_ff.capture_compare_control[CCC_A_CAP];
    assign b_cap = s_ff.capture_compare_control[CCC_B_CAP];
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr = apb_req.psel && apb_req.penable && s_ff.pready
        && apb_req.pwrite;
    assign wb = apb_req.pwdata[7:0];

    tec_edge_det u_edge_a (
        .pclk(pclk),
        .presetn(presetn),
        .en(run),
        .es(s_ff.prescaler_edge_mode[PEM_ESA_LSB +: 2]),
        .pin(event_input_a),
        .edge_valid(edge_a),
        .edge_rev(edge_a_rev)
    );

    tec_edge_det u_edge_b (
        .pclk(pclk),
        .presetn(presetn),
        .en(run),
        .es(s_ff.prescaler_edge_mode[PEM_ESB_LSB +: 2]),
        .pin(event_input_b),
        .edge_valid(edge_b),
        .edge_rev()
    );

    tec_clk_sel u_clk_sel (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .ext(s_ff.clock_selector_control[CSC_EXT_BIT]),
        .sel(s_ff.prescaler_edge_mode[PEM_CS_LSB +: 2]),
        .ext_edge(edge_a),
        .tick(tick)
    );

    // First tick after start only synchronises, hence the extra count
    always_comb
    begin
        match_a_cmp = run && tick && s_ff.started
            && (s_ff.up_counter_value == s_ff.capture_compare_a)
            && (!a_cap || s_ff.mode == MODE_CLR_MATCH);
        match_b_cmp = run && tick && s_ff.started && !b_cap
            && (s_ff.up_counter_value == s_ff.capture_compare_b);
        clr_match = match_a_cmp && s_ff.mode == MODE_CLR_MATCH;
        clr_edge = s_ff.mode == MODE_CLR_EDGE && edge_a;
        hold_clr = s_ff.mode == MODE_CLR_EDGE && event_sel;
        cap_a_trig = run && a_cap && s_ff.mode != MODE_CLR_MATCH
            && (s_ff.capture_compare_control[CCC_A_REV] ? edge_a_rev
            : edge_b);
        cap_b_trig = run && b_cap && edge_a;
        ovf_set = run && tick && s_ff.started
            && s_ff.up_counter_value == CNT_MAX;
        any_clr = !run || clr_match || clr_edge || hold_clr || cap_b_trig;
        toggle = (match_a_cmp && s_ff.output_pin_control[OPC_TOG_A])
            || (match_b_cmp && s_ff.output_pin_control[OPC_TOG_B])
            || (clr_edge && s_ff.output_toggle_condition);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        nxt_s_ff = s_ff;
        nxt_s_ff.irq_a = match_a_cmp || cap_a_trig;
        nxt_s_ff.irq_b = match_b_cmp || cap_b_trig;
        // Software writes, hardware updates below take precedence
        if (wr)
        begin
            case (apb_req.paddr)
                ADDR_MODE:
                begin
                    nxt_s_ff.mode = wb[MODE_LSB +: 2];
                    nxt_s_ff.output_toggle_condition = wb[TCOND_BIT];
                    nxt_s_ff.overflow_flag = wb[OVF_BIT];
                end
                ADDR_CCC: nxt_s_ff.capture_compare_control = wb;
                ADDR_OPC: nxt_s_ff.output_pin_control = wb;
                ADDR_PEM: nxt_s_ff.prescaler_edge_mode = wb;
                ADDR_CSC: nxt_s_ff.clock_selector_control = wb;
                ADDR_CRA: nxt_s_ff.capture_compare_a = apb_req.pwdata[15:0];
                ADDR_CRB: nxt_s_ff.capture_compare_b = apb_req.pwdata[15:0];
                default: nxt_s_ff.pslverr = s_ff.pslverr;
            endcase
        end
        // Trigger bits for the output level are never stored
        nxt_s_ff.output_pin_control[OPC_LVR] = 1'b0;
        nxt_s_ff.output_pin_control[OPC_LVS] = 1'b0;
        // Counter: first tick starts, later ticks add one
        if (run && tick && !s_ff.started)
        begin
            nxt_s_ff.started = 1'b1;
        end
        if (run && tick && s_ff.started)
        begin
            nxt_s_ff.up_counter_value = s_ff.up_counter_value
                + 16'h0001;
        end
        if (any_clr)
        begin
            nxt_s_ff.up_counter_value = RST_WORD;
        end
        if (!run)
        begin
            nxt_s_ff.started = 1'b0;
            nxt_s_ff.overflow_flag = 1'b0;
        end
        if (ovf_set && !any_clr)
        begin
            nxt_s_ff.overflow_flag = 1'b1;
        end
        if (cap_a_trig)
        begin
            nxt_s_ff.capture_compare_a = s_ff.up_counter_value;
        end
        if (cap_b_trig)
        begin
            nxt_s_ff.capture_compare_b = s_ff.up_counter_value;
        end
        // Output pin level
        if (!s_ff.output_pin_control[OPC_TOE])
        begin
            nxt_s_ff.tout = 1'b0;
        end
        else if (wr && apb_req.paddr == ADDR_OPC && wb[OPC_LVS])
        begin
            nxt_s_ff.tout = 1'b1;
        end
        else if (wr && apb_req.paddr == ADDR_OPC && wb[OPC_LVR])
        begin
            nxt_s_ff.tout = 1'b0;
        end
        else if (toggle)
        begin
            nxt_s_ff.tout = !s_ff.tout;
        end
        // APB answer is prepared in the setup cycle, zero wait states
        nxt_s_ff.pready = setup;
        nxt_s_ff.pslverr = 1'b0;
        nxt_s_ff.prdata = '0;
        if (setup)
        begin
            case (apb_req.paddr)
                ADDR_MODE: nxt_s_ff.prdata[7:0] = {4'h0, s_ff.mode,
                    s_ff.output_toggle_condition, s_ff.overflow_flag};
                ADDR_CCC: nxt_s_ff.prdata[7:0] = s_ff.capture_compare_control;
                ADDR_OPC: nxt_s_ff.prdata[7:0] = s_ff.output_pin_control;
                ADDR_PEM: nxt_s_ff.prdata[7:0] = s_ff.prescaler_edge_mode;
                ADDR_CSC: nxt_s_ff.prdata[7:0] = s_ff.clock_selector_control;
                ADDR_CNT: nxt_s_ff.prdata[15:0] = s_ff.up_counter_value;
                ADDR_CRA: nxt_s_ff.prdata[15:0] = s_ff.capture_compare_a;
                ADDR_CRB: nxt_s_ff.prdata[15:0] = s_ff.capture_compare_b;
                default: nxt_s_ff.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s_ff;
        end
    end

    assign apb_rsp.prdata = s_ff.prdata;
    assign apb_rsp.pready = s_ff.pready;
    assign apb_rsp.pslverr = s_ff.pslverr;
    assign timer_output_pin = s_ff.tout;
    assign match_a_interrupt = s_ff.irq_a;
    assign match_b_interrupt = s_ff.irq_b;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_interval_match;
        run && s_ff.mode == MODE_CLR_MATCH && match_a_cmp;
    endsequence

    sequence s_cleared_with_irq_a;
        s_ff.up_counter_value == RST_WORD && match_a_interrupt;
    endsequence

    sequence s_edge_capture_b;
        run && s_ff.mode == MODE_CLR_EDGE && cap_b_trig;
    endsequence

    property p_stop_clears;
        s_ff.mode == MODE_STOP |=> s_ff.up_counter_value == RST_WORD
            && !s_ff.overflow_flag && !s_ff.started;
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("Counter not held clear while stopped");

    property p_match_clear;
        s_interval_match |=> s_cleared_with_irq_a;
    endproperty
    a_match_clear: assert property (p_match_clear)
        else $error("Interval match did not clear and interrupt");

    property p_square_toggle;
        (s_interval_match and (s_ff.output_pin_control == 8'h03))
            |=> timer_output_pin != $past(timer_output_pin);
    endproperty
    a_square_toggle: assert property (p_square_toggle)
        else $error("Square wave output did not invert on match");

    property p_match_b;
        match_b_cmp |=> match_b_interrupt;
    endproperty
    a_match_b: assert property (p_match_b)
        else $error("Compare B match without interrupt");

    property p_overflow;
        ovf_set && !any_clr |=> s_ff.overflow_flag
            && s_ff.up_counter_value == RST_WORD;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("Wrap from maximum did not set overflow");

    property p_edge_clear;
        run && clr_edge ##1 !clr_edge[*2] |-> s_ff.up_counter_value <= 16'h0002;
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("Input A edge did not clear the counter");

    property p_capture_b;
        s_edge_capture_b |=> s_ff.capture_compare_b ==
            $past(s_ff.up_counter_value) && match_b_interrupt
            && s_ff.up_counter_value == RST_WORD;
    endproperty
    a_capture_b: assert property (p_capture_b)
        else $error("Capture into B or following clear missing");

    property p_capture_a;
        cap_a_trig |=> s_ff.capture_compare_a ==
            $past(s_ff.up_counter_value) && match_a_interrupt;
    endproperty
    a_capture_a: assert property (p_capture_a)
        else $error("Capture into A missing");

    property p_increment;
        run && tick && s_ff.started && !any_clr |=> s_ff.up_counter_value
            == $past(s_ff.up_counter_value) + 16'h0001;
    endproperty
    a_increment: assert property (p_increment)
        else $error("Counter did not advance by one");

    property p_clear_wins;
        run && tick && s_ff.started && any_clr
            |=> s_ff.up_counter_value == RST_WORD;
    endproperty
    a_clear_wins: assert property (p_clear_wins)
        else $error("Increment beat a clear");
endmodule // tec_timer

// ---- sim/tec_pins.sv ----
// Behavioural model of the external pulse sources and the output load
`timescale 1ns/1ps
module tec_pins (
    // Clock
    input wire logic pclk,
    // Pins
    output logic event_input_a,
    output logic event_input_b,
    input wire logic timer_output_pin,
    // Observation
    output int toggles
);
    logic pin_last;

    initial
    begin
        event_input_a = 1'b0;
        event_input_b = 1'b0;
        toggles = 0;
        pin_last = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Load side: counts every change of the output level
    always @(posedge pclk)
    begin
        if (timer_output_pin !== pin_last)
        begin
            toggles <= toggles + 1;
        end
        pin_last <= timer_output_pin;
    end

    ////////////////////////////////////////////////////////////////////////
    // High then low, each held hold_cyc clocks; one clock makes a glitch
    task automatic pulse(input bit on_b, input int hold_cyc);
        @(posedge pclk);
        if (on_b)
            event_input_b <= 1'b1;
        else
            event_input_a <= 1'b1;
        repeat (hold_cyc) @(posedge pclk);
        if (on_b)
            event_input_b <= 1'b0;
        else
            event_input_a <= 1'b0;
        repeat (hold_cyc) @(posedge pclk);
    endtask
endmodule // tec_pins

// ---- sim/tb_top.sv ----
// Self-checking testbench of the timer/event counter
`timescale 1ns/1ps
module tb_top;
    import tec_pkg::*;
    // Overflow wait dominates the run
    localparam int CEIL = 80000;
    logic pclk;
    logic presetn;
    tec_apb_req_t req;
    tec_apb_rsp_t rsp;
    logic ev_a;
    logic ev_b;
    logic pin;
    logic irq_a;
    logic irq_b;
    logic err;
    logic [31:0] rd;
    logic [31:0] cra_v;
    int toggles, fails, total_checks, cyc, na, nb, a_last, a_per;
    int base_a, base_b, base_t;

    tec_timer tec_timer_i (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .event_input_a(ev_a), .event_input_b(ev_b),
        .timer_output_pin(pin), .match_a_interrupt(irq_a),
        .match_b_interrupt(irq_b));
    tec_pins tec_pins_i (.pclk(pclk), .event_input_a(ev_a),
        .event_input_b(ev_b), .timer_output_pin(pin), .toggles(toggles));

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        req = '0;
        {fails, total_checks, cyc, na, nb, a_last, a_per} = '0;
    end
    always #12.5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (irq_a === 1'b1)
        begin
            na <= na + 1;
            a_per <= cyc - a_last;
            a_last <= cyc;
        end
        if (irq_b === 1'b1)
            nb <= nb + 1;
        if (cyc == CEIL)
        begin
            fails++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Waits for pready as long as it takes; only the timeout ends a hang
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (rsp.pready !== 1'b1);
        check("pready wait", n, 32'd1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic stop();
        apb(1'b1, ADDR_MODE, 32'h0);
        apb(1'b0, ADDR_CNT, 32'h0);
        check("stopped count", rd, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset value", rd, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, ADDR_CRA, 32'h1234);
        apb(1'b0, ADDR_CRA, 32'h0);
        check("reg a", rd, 32'h1234);
        apb(1'b1, ADDR_CNT, 32'h5555);
        apb(1'b0, ADDR_CNT, 32'h0);
        check("count read only", rd, 32'h0);
        $display("test registers done");

        // Interval timer, square wave, B compare still fires
        apb(1'b1, ADDR_CRA, 32'h5);
        apb(1'b1, ADDR_CRB, 32'h2);
        apb(1'b1, ADDR_OPC, 32'h3);
        base_a = na;
        base_b = nb;
        base_t = toggles;
        apb(1'b1, ADDR_MODE, 32'hC);
        for (int n = 0; n < 3000 && na < base_a + 3; n++)
            @(posedge pclk);
        repeat (2) @(posedge pclk);
        check("interval", a_per, 6);
        check("match b", nb - base_b, 3);
        check("square wave", toggles - base_t, 3);
        stop();
        $display("test interval done");

        // Event counting on rising A edges, A = 3
        apb(1'b1, ADDR_OPC, 32'h0);
        apb(1'b1, ADDR_PEM, 32'h13);
        apb(1'b1, ADDR_CRA, 32'h3);
        base_a = na;
        apb(1'b1, ADDR_MODE, 32'hC);
        for (int i = 1; i < 10; i++)
        begin
            tec_pins_i.pulse(1'b0, 4);
            repeat (4) @(posedge pclk);
            check("events", na - base_a, (i - 1) / 4);
        end
        apb(1'b0, ADDR_CNT, 32'h0);
        cra_v = rd;
        tec_pins_i.pulse(1'b0, 1);
        repeat (8) @(posedge pclk);
        apb(1'b0, ADDR_CNT, 32'h0);
        check("glitch ignored", rd, cra_v);
        stop();
        $display("test event done");

        // Clear on A edge, capture A on B edge, capture B on A edge
        apb(1'b1, ADDR_PEM, 32'h50);
        apb(1'b1, ADDR_CCC, 32'h5);
        apb(1'b1, ADDR_OPC, 32'h1);
        apb(1'b1, ADDR_MODE, 32'hA);
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_CNT, 32'h0);
        check("started", {31'h0, rd > 32'd20}, 32'h1);
        base_a = na;
        base_b = nb;
        base_t = toggles;
        tec_pins_i.pulse(1'b1, 4);
        repeat (6) @(posedge pclk);
        check("capture a irq", na - base_a, 1);
        apb(1'b0, ADDR_CRA, 32'h0);
        check("capture a", {31'h0, rd > 32'd40}, 32'h1);
        cra_v = rd;
        tec_pins_i.pulse(1'b0, 4);
        repeat (6) @(posedge pclk);
        apb(1'b0, ADDR_CNT, 32'h0);
        check("cleared", {31'h0, rd < 32'd24}, 32'h1);
        check("capture b irq", nb - base_b, 1);
        check("edge toggle", toggles - base_t, 1);
        apb(1'b0, ADDR_CRB, 32'h0);
        check("capture b", {31'h0, rd > cra_v}, 32'h1);
        // No further edges, so the counter must wrap
        repeat (65540) @(posedge pclk);
        apb(1'b0, ADDR_MODE, 32'h0);
        check("overflow", {31'h0, rd[OVF_BIT]}, 32'h1);
        stop();
        apb(1'b0, ADDR_MODE, 32'h0);
        check("stop clears flag", rd, 32'h0);
        // Mode 10, both compare, A = 0: match only after each clear
        apb(1'b1, ADDR_CCC, 32'h0);
        apb(1'b1, ADDR_OPC, 32'h3);
        apb(1'b1, ADDR_CRA, 32'h0);
        apb(1'b1, ADDR_CRB, 32'h3);
        apb(1'b1, ADDR_MODE, 32'h8);
        repeat (10) @(posedge pclk);
        base_a = na;
        base_b = nb;
        base_t = toggles;
        tec_pins_i.pulse(1'b0, 4);
        repeat (6) @(posedge pclk);
        check("zero match", na - base_a, 1);
        check("compare b", nb - base_b, 1);
        check("match toggle only", toggles - base_t, 1);
        stop();
        $display("test clear mode done");
        results();
    end
endmodule // tb_top
